/* design/mcsr_pkg.sv */
// Purpose: Constants and types for the metering control and status register bank
// Assumes: One clock (master clock), register port driven by the serial front end
// Notes:   Offsets are register addresses on the internal register port
//
// What this block does
// - Rate code 11 updates waveform every 1024 clocks
// - Codes 00,01,10 give 128, 256, 512 clocks
// - Mode bits 14:13 select waveform source
// - Source 00 power filter, 10 ch1, 11 ch2
// - Source 01 loads combined 40-bit ch1/ch2 word
// - Mode bit 15 enters factory test mode
// - Each event sets its status flag high
// - Interrupt request low while enabled flag other than bit 6 set
// - Bit 0 set on energy MSB rising
// - Bit 1 set on dip or lost crossings
// - Bit 2 set at half-cycle accumulation end
// - Bit 3 set on new waveform sample
// - Bit 4 follows zero crossing level
// - Bit 5 set on temperature result ready
// - Bit 6 set after reset, never interrupts
// - Bit 7 set on energy register overflow
// - Channel 1 offset register is 8-bit RW
// - Offset bits 4:0 magnitude, bit 5 sign
// - Bit 7 integrator enable, resets 1; bit 6 unused
package mcsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register addresses (mode and mask addresses are local choices)
    localparam logic [7:0] ADDR_MODE  = 8'h06;
    localparam logic [7:0] ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ADDR_FLRC  = 8'h05;
    localparam logic [7:0] ADDR_CHANNEL1_OFFSET_INTEGRATOR = 8'h08;
    localparam logic [7:0] ADDR_MASK  = 8'h0A;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int RATE_LSB   = 11;
    localparam int SRC_LSB    = 13;
    localparam int TEST_BIT   = 15;
    localparam int OFS_SIGN   = 5;
    localparam int INTEG_BIT  = 7;
    localparam int FLG_EHF    = 0;
    localparam int FLG_SAG    = 1;
    localparam int FLG_CYC    = 2;
    localparam int FLG_WAVEFORM_SAMPLE_FLAG   = 3;
    localparam int FLG_ZX     = 4;
    localparam int FLG_TEMP   = 5;
    localparam int FLG_RESET  = 6;
    localparam int FLG_EOF    = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] MODE_RST  = 16'h000C;
    localparam logic [7:0]  MASK_RST  = 8'h00;
    localparam logic [7:0]  CHANNEL1_OFFSET_INTEGRATOR_RST = 8'h80;
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [7:0]  WR_MASK_CHANNEL1_OFFSET_INTEGRATOR = 8'hBF;

    ////////////////////////////////////////////////////////////////////////////
    // Waveform update dividers, as log2 of master clocks per sample
    localparam int DIV_LOG2_BASE = 7;
    localparam int DIV_CNT_W     = 10;

    typedef enum logic [1:0] {
        MCSR_SRC_POWER = 2'b00,
        MCSR_SRC_BOTH  = 2'b01,
        MCSR_SRC_CH1   = 2'b10,
        MCSR_SRC_CH2   = 2'b11
    } mcsr_src_e;

    typedef struct packed {
        logic energy_msb;
        logic sag;
        logic cycle_done;
        logic zero_cross;
        logic temp_done;
        logic energy_ovf;
    } mcsr_events_s;

    typedef struct packed {
        logic [23:0] ch1;
        logic [23:0] ch2;
        logic [23:0] power;
    } mcsr_samples_s;

endpackage

/* design/mcsr_regs.sv */
// Purpose: Mode, status, mask and channel 1 offset registers with interrupt request
// Assumes: Register port and event inputs come from logic on clk_i;
//          zero crossing level and dip come from pins and are synchronised
// Notes:   Interrupt request is open drain: line low while irq_oe_o is high
`timescale 1ns/1ps
`default_nettype none

module mcsr_regs (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    // Software reset pulse from mode logic
    input  wire logic                        sw_reset_i,
    // Register port
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    input  wire logic [7:0]                  reg_addr_i,
    input  wire logic [15:0]                 reg_wdata_i,
    output logic      [15:0]                 reg_rdata_o,
    // Events
    input  wire mcsr_pkg::mcsr_events_s      events_i,
    input  wire mcsr_pkg::mcsr_samples_s     samples_i,
    // Waveform output
    output logic      [39:0]                 waveform_o,
    // Configuration to datapath
    output logic      [1:0]                  waveform_rate_sel_o,
    output logic      [1:0]                  waveform_source_sel_o,
    output logic                             factory_test_o,
    output logic      [5:0]                  ch1_offset_o,
    output logic                             ch1_integrator_on_o,
    // Interrupt request, open drain
    output logic                             irq_o,
    output logic                             irq_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for pin levels

    logic [1:0] zx_sync_r;
    logic [1:0] sag_sync_r;
    logic       sag_prev_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            zx_sync_r  <= 2'h0;
            sag_sync_r <= 2'h0;
            sag_prev_r <= 1'b0;
        end else begin
            zx_sync_r  <= {zx_sync_r[0], events_i.zero_cross};
            sag_sync_r <= {sag_sync_r[0], events_i.sag};
            sag_prev_r <= sag_sync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [15:0] mode_r;
    logic [7:0]  mask_r;
    logic [7:0]  channel1_offset_integrator_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_r <= mcsr_pkg::MODE_RST;
        end else if (sw_reset_i) begin
            mode_r <= mcsr_pkg::MODE_RST;
        end else if (reg_wr_i && hit(reg_addr_i, mcsr_pkg::ADDR_MODE)) begin
            mode_r <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_r <= mcsr_pkg::MASK_RST;
        end else if (sw_reset_i) begin
            mask_r <= mcsr_pkg::MASK_RST;
        end else if (reg_wr_i && hit(reg_addr_i, mcsr_pkg::ADDR_MASK)) begin
            mask_r <= reg_wdata_i[7:0];
        end
    end

    // Bit 6 is unused and kept at zero
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            channel1_offset_integrator_r <= mcsr_pkg::CHANNEL1_OFFSET_INTEGRATOR_RST;
        end else if (sw_reset_i) begin
            channel1_offset_integrator_r <= mcsr_pkg::CHANNEL1_OFFSET_INTEGRATOR_RST;
        end else if (reg_wr_i && hit(reg_addr_i, mcsr_pkg::ADDR_CHANNEL1_OFFSET_INTEGRATOR)) begin
            channel1_offset_integrator_r <= reg_wdata_i[7:0] & mcsr_pkg::WR_MASK_CHANNEL1_OFFSET_INTEGRATOR;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            waveform_rate_sel_o   <= 2'h0;
            waveform_source_sel_o <= 2'h0;
            factory_test_o        <= 1'b0;
            ch1_offset_o          <= 6'h00;
            ch1_integrator_on_o   <= 1'b1;
        end else begin
            waveform_rate_sel_o   <= mode_r[mcsr_pkg::RATE_LSB +: 2];
            waveform_source_sel_o <= mode_r[mcsr_pkg::SRC_LSB +: 2];
            factory_test_o        <= mode_r[mcsr_pkg::TEST_BIT];
            ch1_offset_o          <= channel1_offset_integrator_r[mcsr_pkg::OFS_SIGN:0];
            ch1_integrator_on_o   <= channel1_offset_integrator_r[mcsr_pkg::INTEG_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waveform sample timer and loader

    logic [mcsr_pkg::DIV_CNT_W-1:0] div_r;
    logic [mcsr_pkg::DIV_CNT_W-1:0] div_last;
    logic [mcsr_pkg::DIV_CNT_W:0]   div_period;
    logic [mcsr_pkg::DIV_CNT_W:0]   div_period_m1;
    logic                           waveform_sample_flag_pulse_r;

    // Period is 128 << rate code: 128, 256, 512, 1024 clocks
    // One extra bit holds 1024 before the terminal count is taken
    assign div_period    = 11'h001 << (mcsr_pkg::DIV_LOG2_BASE + mode_r[mcsr_pkg::RATE_LSB +: 2]);
    assign div_period_m1 = div_period - 11'h001;
    assign div_last      = div_period_m1[mcsr_pkg::DIV_CNT_W-1:0];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r        <= '0;
            waveform_sample_flag_pulse_r <= 1'b0;
        end else if (div_r >= div_last) begin
            div_r        <= '0;
            waveform_sample_flag_pulse_r <= 1'b1;
        end else begin
            div_r        <= div_r + 1'b1;
            waveform_sample_flag_pulse_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            waveform_o <= 40'h0;
        end else if (div_r >= div_last) begin
            case (mode_r[mcsr_pkg::SRC_LSB +: 2])
                mcsr_pkg::MCSR_SRC_POWER: waveform_o <= {16'h0, samples_i.power};
                mcsr_pkg::MCSR_SRC_BOTH: waveform_o <= {samples_i.ch1[23:4],
                                                        samples_i.ch2[23:4]};
                mcsr_pkg::MCSR_SRC_CH1:  waveform_o <= {16'h0, samples_i.ch1};
                mcsr_pkg::MCSR_SRC_CH2:  waveform_o <= {16'h0, samples_i.ch2};
                default:                 waveform_o <= 40'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags

    logic [7:0] flags_r;
    logic [7:0] flags_view;
    logic [7:0] set_vec;
    logic       rd_clear;
    logic       rst_done_r;

    assign rd_clear = reg_rd_i && hit(reg_addr_i, mcsr_pkg::ADDR_FLRC);

    // Zero crossing bit is live, the others sticky
    always_comb begin
        set_vec = 8'h00;
        set_vec[mcsr_pkg::FLG_EHF]   = events_i.energy_msb;
        set_vec[mcsr_pkg::FLG_SAG]   = sag_sync_r[1] && !sag_prev_r;
        set_vec[mcsr_pkg::FLG_CYC]   = events_i.cycle_done;
        set_vec[mcsr_pkg::FLG_WAVEFORM_SAMPLE_FLAG]  = waveform_sample_flag_pulse_r;
        set_vec[mcsr_pkg::FLG_TEMP]  = events_i.temp_done;
        set_vec[mcsr_pkg::FLG_RESET] = rst_done_r;
        set_vec[mcsr_pkg::FLG_EOF]   = events_i.energy_ovf;
        flags_view = flags_r;
        flags_view[mcsr_pkg::FLG_ZX] = zx_sync_r[1];
    end

    // Flag 6 raised one cycle after any reset ends
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_done_r <= 1'b1;
        end else begin
            rst_done_r <= sw_reset_i;
        end
    end

    // Set wins over a simultaneous read-clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_r <= mcsr_pkg::FLAGS_RST;
        end else if (rd_clear) begin
            flags_r <= set_vec;
        end else begin
            flags_r <= flags_r | set_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request; reset flag excluded from the or, live zero crossing included

    logic [7:0] irq_src;

    always_comb begin
        irq_src = flags_r & mask_r;
        irq_src[mcsr_pkg::FLG_RESET] = 1'b0;
        irq_src[mcsr_pkg::FLG_ZX] = zx_sync_r[1] & mask_r[mcsr_pkg::FLG_ZX];
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_o    <= 1'b0;
            irq_oe_o <= 1'b0;
        end else begin
            irq_o    <= 1'b0;
            irq_oe_o <= |irq_src;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, registered one cycle after the read strobe

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 16'h0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                mcsr_pkg::ADDR_MODE:  reg_rdata_o <= mode_r;
                mcsr_pkg::ADDR_FLAGS: reg_rdata_o <= {8'h0, flags_view};
                mcsr_pkg::ADDR_FLRC:  reg_rdata_o <= {8'h0, flags_view};
                mcsr_pkg::ADDR_CHANNEL1_OFFSET_INTEGRATOR: reg_rdata_o <= {8'h0, channel1_offset_integrator_r};
                mcsr_pkg::ADDR_MASK:  reg_rdata_o <= {8'h0, mask_r};
                default:              reg_rdata_o <= 16'h0;
            endcase
        end
    end

endmodule

`default_nettype wire

/* tb/mcsr_host.sv */
// Purpose: Host model on the register port
// Assumes: Requests launched at the falling edge
// Notes:   Write data is inverted once released
`timescale 1ns/1ps
`default_nettype none
module mcsr_host (
    // Clock and read data
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    // Requests
    output logic             wr_o = 1'b0,
    output logic             rd_o = 1'b0,
    output logic [7:0]       addr_o = 8'h00,
    output logic [15:0]      wdata_o = 16'h0000
);
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        {wr_o, addr_o, wdata_o} = {1'b1, a, d};
        @(negedge clk_i);
        {wr_o, wdata_o} = {1'b0, ~d};
    endtask
    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk_i);
        {rd_o, addr_o} = {1'b1, a};
        @(negedge clk_i);
        rd_o = 1'b0;
        @(negedge clk_i);
        d = rdata_i;
    endtask
    task automatic isr(output logic [15:0] d);
        rd(mcsr_pkg::ADDR_FLRC, d);
    endtask
endmodule
`default_nettype wire

/* tb/mcsr_regs_chk.sv */
// Purpose: Port assertions for mcsr_regs
// Assumes: One-cycle register strobes
// Notes:   Fields trail a write by two edges
`timescale 1ns/1ps
`default_nettype none
module mcsr_regs_chk (
    // Clock and resets
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        sw_reset_i,
    // Register port
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    // Fields and request
    input wire logic [1:0]  waveform_rate_sel_o,
    input wire logic [1:0]  waveform_source_sel_o,
    input wire logic        factory_test_o,
    input wire logic [5:0]  ch1_offset_o,
    input wire logic        ch1_integrator_on_o,
    input wire logic        irq_oe_o
);
    logic mw;
    logic ow;
    assign mw = reg_wr_i && reg_addr_i == mcsr_pkg::ADDR_MODE;
    assign ow = reg_wr_i && reg_addr_i == mcsr_pkg::ADDR_CHANNEL1_OFFSET_INTEGRATOR;
    // Software reset restores defaults, so it aborts pending checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i || sw_reset_i);
    a_rate_follow: assert property (
        mw |-> ##2 waveform_rate_sel_o == $past(reg_wdata_i[12:11], 2)) else $error("rate");
    a_src_follow: assert property (
        mw |-> ##2 waveform_source_sel_o == $past(reg_wdata_i[14:13], 2)) else $error("src");
    a_test_follow: assert property (
        mw |-> ##2 factory_test_o == $past(reg_wdata_i[15], 2)) else $error("test bit");
    a_offset_follow: assert property (
        ow |-> ##2 ch1_offset_o == $past(reg_wdata_i[5:0], 2)) else $error("offset");
    a_integ_follow: assert property (
        ow |-> ##2 ch1_integrator_on_o == $past(reg_wdata_i[7], 2)) else $error("integ");
    a_unused_zero: assert property (
        reg_rd_i && reg_addr_i == mcsr_pkg::ADDR_CHANNEL1_OFFSET_INTEGRATOR |=> !reg_rdata_o[6]) else $error("bit6");
    a_rdata_hold: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
    a_mask_off: assert property (
        reg_wr_i && reg_addr_i == mcsr_pkg::ADDR_MASK && reg_wdata_i[7:0] == 8'h00
        |-> ##[1:3] !irq_oe_o) else $error("irq kept");
endmodule
bind mcsr_regs mcsr_regs_chk u_chk (.clk_i, .reset_n_i, .sw_reset_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .waveform_rate_sel_o, .waveform_source_sel_o,
    .factory_test_o, .ch1_offset_o, .ch1_integrator_on_o, .irq_oe_o);
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for mcsr_regs
// Assumes: Inputs change at the falling edge
// Notes:   Flag bit 3 runs free, so it is masked in flag checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                    clk_i = 1'b0;
    logic                    reset_n_i = 1'b0;
    logic                    sw_reset_i = 1'b0;
    logic                    reg_wr_i, reg_rd_i, factory_test_o, ch1_integrator_on_o;
    logic                    irq_o, irq_oe_o;
    logic [7:0]              reg_addr_i;
    logic [15:0]             reg_wdata_i, reg_rdata_o, d;
    logic [39:0]             waveform_o;
    logic [5:0]              ch1_offset_o;
    logic [1:0]              waveform_rate_sel_o, waveform_source_sel_o;
    mcsr_pkg::mcsr_events_s  ev = '0;
    mcsr_pkg::mcsr_samples_s smp = {24'hA5A5A5, 24'h3C3C3C, 24'h123456};
    int                      bad_count = 0;
    int                      n_checks = 0;
    time                     t0;
    initial forever #5 clk_i = ~clk_i;
    mcsr_host host (.clk_i, .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
    mcsr_regs dut (.clk_i, .reset_n_i, .sw_reset_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .events_i(ev), .samples_i(smp), .waveform_o,
        .waveform_rate_sel_o, .waveform_source_sel_o, .factory_test_o, .ch1_offset_o,
        .ch1_integrator_on_o, .irq_o, .irq_oe_o);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        host.rd(mcsr_pkg::ADDR_CHANNEL1_OFFSET_INTEGRATOR, d);
        chk(d, 16'h0080);
        host.wr(mcsr_pkg::ADDR_MASK, 16'h0040);
        cyc(4);
        chk(irq_oe_o, 1'b0);
        host.isr(d);
        chk(d[7:0] & 8'hF7, 8'h40);
        host.rd(mcsr_pkg::ADDR_FLAGS, d);
        chk(d[7:0] & 8'hF7, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_events();
        int eb[5] = '{5, 4, 3, 1, 0};
        int fb[5] = '{0, 1, 2, 5, 7};
        host.wr(mcsr_pkg::ADDR_MASK, 16'h00B7);
        foreach (eb[i]) begin
            ev[eb[i]] = 1'b1;
            cyc(1);
            ev = '0;
            cyc(5);
            chk({irq_o, irq_oe_o}, 2'b01);
            host.isr(d);
            chk(d[7:0] & 8'hF7, 8'h01 << fb[i]);
            cyc(3);
            chk(irq_oe_o, 1'b0);
        end
        host.wr(mcsr_pkg::ADDR_MASK, 16'h0010);
        ev.zero_cross = 1'b1;
        cyc(5);
        chk(irq_oe_o, 1'b1);
        ev.zero_cross = 1'b0;
        cyc(5);
        chk(irq_oe_o, 1'b0);
        host.wr(mcsr_pkg::ADDR_MASK, 16'h0000);
        $display("event test done");
    endtask
    task automatic t_regs();
        host.wr(mcsr_pkg::ADDR_CHANNEL1_OFFSET_INTEGRATOR, 16'hFFFF);
        host.rd(mcsr_pkg::ADDR_CHANNEL1_OFFSET_INTEGRATOR, d);
        chk(d, 16'h00BF);
        chk({ch1_integrator_on_o, ch1_offset_o}, 7'h7F);
        host.wr(mcsr_pkg::ADDR_CHANNEL1_OFFSET_INTEGRATOR, 16'h0025);
        cyc(2);
        chk({ch1_integrator_on_o, ch1_offset_o}, 7'h25);
        host.wr(mcsr_pkg::ADDR_MODE, 16'h800C);
        cyc(2);
        chk(factory_test_o, 1'b1);
        sw_reset_i = 1'b1;
        cyc(1);
        sw_reset_i = 1'b0;
        cyc(4);
        host.rd(mcsr_pkg::ADDR_FLAGS, d);
        chk(d[6], 1'b1);
        host.rd(mcsr_pkg::ADDR_MODE, d);
        chk(d, 16'h000C);
        $display("register test done");
    endtask
    task automatic t_wave();
        for (int s = 0; s < 4; s++) begin
            host.wr(mcsr_pkg::ADDR_MODE, {1'b0, s[1:0], 13'h000C});
            cyc(300);
            chk(waveform_source_sel_o, s[1:0]);
            if (s == 1) chk(waveform_o, {20'hA5A5A, 20'h3C3C3});
            else chk(waveform_o, {16'h0000, s == 0 ? 24'h123456 : s == 2 ? 24'hA5A5A5 : 24'h3C3C3C});
        end
        host.wr(mcsr_pkg::ADDR_MASK, 16'h0008);
        for (int r = 0; r < 4; r++) begin
            host.wr(mcsr_pkg::ADDR_MODE, {3'b000, r[1:0], 11'h00C});
            host.isr(d);
            @(posedge irq_oe_o);
            host.isr(d);
            @(posedge irq_oe_o);
            t0 = $time;
            host.isr(d);
            @(posedge irq_oe_o);
            chk(($time - t0) / 10, 128 << r);
        end
        $display("waveform test done");
    endtask
    initial begin
        cyc(2);
        reset_n_i = 1'b1;
        t_reset();
        t_events();
        t_regs();
        t_wave();
        summarize();
    end
    // Tests need well under this many cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
